//--- verilog/sgr_pkg.sv
// Package for the sound generator register bank: offsets, fields, resets, timing.
// Assumes a 100 MHz system clock and a plain strobe register port.
package sgr_pkg;

    // ------------------------------------------------------------------
    // Register offsets (word index on the plain port)
    // ------------------------------------------------------------------
    localparam logic [3:0] OFF_CLK  = 4'h0;
    localparam logic [3:0] OFF_SEL  = 4'h1;
    localparam logic [3:0] OFF_CTL  = 4'h2;
    localparam logic [3:0] OFF_DAT  = 4'h3;
    localparam logic [3:0] OFF_INTF = 4'h4;
    localparam logic [3:0] OFF_INTE = 4'h5;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CLK_DEBUG_CLOCK_RUN   = 8;
    localparam int CLK_DIV_LO  = 4;
    localparam int CLK_SRC_LO  = 0;
    localparam int SEL_TEMPO   = 8;
    localparam int SEL_DRIVE   = 2;
    localparam int SEL_MODE    = 0;
    localparam int CTL_STOP    = 8;
    localparam int CTL_EN      = 0;
    localparam int DAT_TIE     = 15;
    localparam int DAT_REST    = 14;
    localparam int DAT_LEN_LO  = 8;
    localparam int INTF_BUSY   = 8;
    localparam int INTF_EMPTY  = 1;
    localparam int INTF_DONE   = 0;

    // ------------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] SRC_INTERNAL_OSCILLATOR  = 2'h0;
    localparam logic [1:0] SRC_LSX   = 2'h1;
    localparam logic [1:0] SRC_HSO   = 2'h2;
    localparam logic [1:0] SRC_EXT   = 2'h3;
    localparam logic [2:0] DIV_MAX   = 3'h5;
    localparam logic [2:0] DIV_ONE   = 3'h7;
    localparam logic [1:0] MODE_NORM = 2'h0;
    localparam logic [1:0] MODE_ONE  = 2'h1;
    localparam logic [1:0] MODE_MEL  = 2'h2;
    localparam logic [15:0] DAT_RESET = 16'h00FF;
    localparam logic [3:0]  DIV_BASE_LOG2 = 4'h4;

    // Tone counter: 32 tone ticks per buffer-length unit, tempo scales note time.
    localparam int TONE_W = 8;
    localparam int TICK_W = 16;
    localparam logic [TICK_W-1:0] NOTE_UNIT = 16'h0200;

    typedef enum logic [1:0] {
        SGR_IDLE,
        SGR_PLAY,
        SGR_STOP
    } sgr_state_t;

endpackage : sgr_pkg

//--- verilog/sgr_tick_if.sv
// Interface carrying the gated operating tick between the divider and the core.
// Assumes both ends sit on clk_sys.
interface sgr_tick_if;
    logic       tick;
    logic [1:0] src;
    logic [2:0] div;
    logic       run;
    modport gen  (output tick, input src, input div, input run);
    modport core (input tick, output src, output div, output run);
endinterface : sgr_tick_if

//--- verilog/sgr_clkdiv.sv
// Operating clock enable generator: source select and power-of-two divider.
// Assumes source clocks arrive as raw pins, synchronised here.
module sgr_clkdiv (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [3:0] src_clk,
    sgr_tick_if.gen         t
);
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic [3:0]  s3;
    logic [8:0]  cnt;
    logic        edge_in;
    logic [8:0]  mask;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1 <= 4'h0;
            s2 <= 4'h0;
            s3 <= 4'h0;
        end else begin
            s1 <= src_clk;
            s2 <= s1;
            s3 <= s2;
        end
    end

    assign edge_in = s2[t.src] & ~s3[t.src];
    // A low-bit mask makes exactly one tick per full count of the divide ratio.
    assign mask = 9'((10'h001 << (int'(t.div) + int'(sgr_pkg::DIV_BASE_LOG2))) - 10'h001);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt <= 9'h000;
        end else if (!t.run) begin
            cnt <= 9'h000;
        end else if (edge_in) begin
            cnt <= cnt + 9'h001;
        end
    end

    always_comb begin
        if (t.div == sgr_pkg::DIV_ONE) begin
            t.tick = t.run & edge_in & (t.src == sgr_pkg::SRC_LSX || t.src == sgr_pkg::SRC_EXT);
        end else if (t.div <= sgr_pkg::DIV_MAX) begin
            t.tick = t.run & edge_in & ((cnt & mask) == mask);
        end else begin
            t.tick = 1'b0;
        end
    end
endmodule : sgr_clkdiv

//--- verilog/sgr_top.sv
// Sound generator register bank and tone sequencer with buzzer pin pair.
// Assumes a plain strobe register port and raw oscillator pins on src_clk.
// Operation
// - Debug halts operating clock unless debug run bit is set.
// - Two-bit source field picks among four oscillator sources.
// - Divider codes 0-5 divide 16..512; code 7 passes slow sources.
// - Tempo field sets melody tempo or one-shot duration.
// - Select bit 2 chooses normal or direct pin drive.
// - Output mode field: normal buzzer, one-shot, melody; 3 reserved.
// - Writing stop bit starts stop; reads one until output ends.
// - Stop forcibly ends one-shot and melody output.
// - Unit enable supplies clock and enables the generator.
// - Writing the sound buffer starts sound output.
// - Tie bit joins notes in melody mode only.
// - Rest holds buzzer low and inverted output high; the code applies rest in melody mode only.
// - Length field sets note duration or buzzer duty.
// - Buzzer modes use only low six pitch bits.
// - Byte writes to the sound buffer are discarded.
// - Busy flag reads one while sound is output.
// - Buffer empty flag resets to one, clears on buffer write.
// - Done flag clears by writing one or buffer write.
// - Each flag has its own interrupt enable bit; the code gives the busy flag none.
// - Empty flag sets on buffer transfer or stop write.
// - Done flag sets when sound output finishes.
// - Interrupt request only while flag and enable both set.
//
// Strobed register access and the register addresses were decided locally.
module sgr_top (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic [1:0]  reg_be,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic [3:0]  src_clk,
    input  wire logic        debug_mode,
    output logic             buzzer_out,
    output logic             buzzer_out_inverted,
    output logic             irq
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic                   debug_clock_run;
    logic [2:0]             clock_divider_select;
    logic [1:0]             clock_source_select;
    logic [3:0]             tempo_duration_select;
    logic                   drive_mode_select;
    logic [1:0]             output_mode_select;
    logic                   unit_enable;
    logic                   sound_stop;
    logic [15:0]            sound_buffer_data;
    logic                   buffer_full;
    logic                   buffer_empty_flag;
    logic                   output_done_flag;
    logic                   buffer_empty_irq_enable;
    logic                   output_done_irq_enable;
    logic                   dbg_s1;
    logic                   dbg_s2;
    sgr_pkg::sgr_state_t    state;
    logic [15:0]            active;
    logic [sgr_pkg::TONE_W-1:0] tone_cnt;
    logic [sgr_pkg::TICK_W-1:0] dur_cnt;
    logic                   wave;
    logic                   wr_clk;
    logic                   wr_sel;
    logic                   wr_ctl;
    logic                   wr_dat;
    logic                   wr_intf;
    logic                   wr_inte;
    logic                   load;
    logic                   finish;
    logic                   dur_end;
    logic                   stop_req;
    logic                   busy;
    logic [sgr_pkg::TICK_W-1:0] next_dur;
    logic [7:0]             period;
    logic [7:0]             duty;

    sgr_tick_if ti ();

    sgr_clkdiv u_div (
        .clk_sys (clk_sys),
        .rst     (rst),
        .src_clk (src_clk),
        .t       (ti.gen)
    );

    // ------------------------------------------------------------------
    // Clock supply
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dbg_s1 <= 1'b0;
            dbg_s2 <= 1'b0;
        end else begin
            dbg_s1 <= debug_mode;
            dbg_s2 <= dbg_s1;
        end
    end

    assign ti.src = clock_source_select;
    assign ti.div = clock_divider_select;
    assign ti.run = unit_enable & (debug_clock_run | ~dbg_s2);

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    assign wr_clk  = reg_wr && reg_addr == sgr_pkg::OFF_CLK;
    assign wr_sel  = reg_wr && reg_addr == sgr_pkg::OFF_SEL;
    assign wr_ctl  = reg_wr && reg_addr == sgr_pkg::OFF_CTL;
    assign wr_dat  = reg_wr && reg_addr == sgr_pkg::OFF_DAT && reg_be == 2'h3;
    assign wr_intf = reg_wr && reg_addr == sgr_pkg::OFF_INTF;
    assign wr_inte = reg_wr && reg_addr == sgr_pkg::OFF_INTE;
    // Stop request on write of one.
    assign stop_req = wr_ctl && reg_wdata[sgr_pkg::CTL_STOP];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            debug_clock_run      <= 1'b0;
            clock_divider_select <= 3'h0;
            clock_source_select  <= 2'h0;
        end else if (wr_clk && !unit_enable) begin
            debug_clock_run      <= reg_wdata[sgr_pkg::CLK_DEBUG_CLOCK_RUN];
            clock_divider_select <= reg_wdata[sgr_pkg::CLK_DIV_LO +: 3];
            clock_source_select  <= reg_wdata[sgr_pkg::CLK_SRC_LO +: 2];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tempo_duration_select <= 4'h0;
            drive_mode_select     <= 1'b0;
            output_mode_select    <= 2'h0;
        end else if (wr_sel) begin
            tempo_duration_select <= reg_wdata[sgr_pkg::SEL_TEMPO +: 4];
            drive_mode_select     <= reg_wdata[sgr_pkg::SEL_DRIVE];
            output_mode_select    <= reg_wdata[sgr_pkg::SEL_MODE +: 2];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            unit_enable <= 1'b0;
        end else if (wr_ctl) begin
            unit_enable <= reg_wdata[sgr_pkg::CTL_EN];
        end
    end

    // Stop bit stands until output ends.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sound_stop <= 1'b0;
        end else if (stop_req && busy) begin
            sound_stop <= 1'b1;
        end else if (!busy) begin
            sound_stop <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sound_buffer_data <= sgr_pkg::DAT_RESET;
            buffer_full       <= 1'b0;
        end else begin
            if (wr_dat) begin
                sound_buffer_data <= reg_wdata;
            end
            if (wr_dat) begin
                buffer_full <= 1'b1;
            end else if (load || stop_req) begin
                buffer_full <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    assign load = ti.tick && buffer_full && !sound_stop
                  && (state == sgr_pkg::SGR_IDLE || dur_end);
    assign dur_end = ti.tick && dur_cnt == '0 && output_mode_select != sgr_pkg::MODE_NORM;
    assign finish = (state == sgr_pkg::SGR_PLAY && dur_end && !load)
                    || state == sgr_pkg::SGR_STOP;
    assign busy = state != sgr_pkg::SGR_IDLE;

    always_comb begin
        if (output_mode_select == sgr_pkg::MODE_MEL) begin
            next_dur = sgr_pkg::TICK_W'(({10'h000, reg_len(sound_buffer_data)} + 16'h0001)
                       * ({12'h000, tempo_duration_select} + 16'h0001)
                       * sgr_pkg::NOTE_UNIT >> 4);
        end else begin
            next_dur = sgr_pkg::TICK_W'(({12'h000, tempo_duration_select} + 16'h0001)
                       * sgr_pkg::NOTE_UNIT);
        end
    end

    function automatic logic [5:0] reg_len(input logic [15:0] d);
        reg_len = d[sgr_pkg::DAT_LEN_LO +: 6];
    endfunction

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= sgr_pkg::SGR_IDLE;
        end else begin
            case (state)
                sgr_pkg::SGR_IDLE: begin
                    if (load) begin
                        state <= sgr_pkg::SGR_PLAY;
                    end
                end
                sgr_pkg::SGR_PLAY: begin
                    if (stop_req || !unit_enable) begin
                        state <= sgr_pkg::SGR_STOP;
                    end else if (dur_end && !load) begin
                        state <= sgr_pkg::SGR_IDLE;
                    end
                end
                sgr_pkg::SGR_STOP: begin
                    state <= sgr_pkg::SGR_IDLE;
                end
                default: begin
                    state <= sgr_pkg::SGR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            active  <= sgr_pkg::DAT_RESET;
            dur_cnt <= '0;
        end else if (load) begin
            active  <= sound_buffer_data;
            dur_cnt <= next_dur;
        end else if (ti.tick && dur_cnt != '0) begin
            dur_cnt <= dur_cnt - 1'b1;
        end
    end

    // Buzzer modes use low six pitch bits.
    assign period = (output_mode_select == sgr_pkg::MODE_MEL)
                    ? active[7:0] : {2'h0, active[5:0]};
    // Duty in buzzer modes scaled from length field.
    assign duty = (output_mode_select == sgr_pkg::MODE_MEL)
                  ? {1'b0, period[7:1]} : 8'((16'(period) * 16'(active[13:8] + 6'h1)) >> 6);

    // Tone wave; a tie keeps phase so joined notes do not click.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tone_cnt <= '0;
            wave     <= 1'b0;
        end else if (state != sgr_pkg::SGR_PLAY) begin
            tone_cnt <= '0;
            wave     <= 1'b0;
        end else if (load && !(active[sgr_pkg::DAT_TIE] && output_mode_select == sgr_pkg::MODE_MEL)) begin
            tone_cnt <= '0;
            wave     <= 1'b0;
        end else if (ti.tick) begin
            tone_cnt <= (tone_cnt >= period) ? '0 : tone_cnt + 1'b1;
            wave     <= tone_cnt < duty;
        end
    end

    // Rest and drive mode on pins.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            buzzer_out          <= 1'b0;
            buzzer_out_inverted <= 1'b1;
        end else if (state != sgr_pkg::SGR_PLAY
                     || (output_mode_select == sgr_pkg::MODE_MEL && active[sgr_pkg::DAT_REST])) begin
            buzzer_out          <= 1'b0;
            buzzer_out_inverted <= 1'b1;
        end else begin
            buzzer_out          <= wave;
            buzzer_out_inverted <= drive_mode_select ? ~wave : 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Flags and interrupts
    // ------------------------------------------------------------------
    // Empty flag, set wins over clear.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            buffer_empty_flag <= 1'b1;
        end else if (load || stop_req) begin
            buffer_empty_flag <= 1'b1;
        end else if (wr_dat) begin
            buffer_empty_flag <= 1'b0;
        end
    end

    // Done flag, set wins over clear.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            output_done_flag <= 1'b0;
        end else if (finish) begin
            output_done_flag <= 1'b1;
        end else if (wr_dat || (wr_intf && reg_wdata[sgr_pkg::INTF_DONE])) begin
            output_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            buffer_empty_irq_enable <= 1'b0;
            output_done_irq_enable  <= 1'b0;
        end else if (wr_inte) begin
            buffer_empty_irq_enable <= reg_wdata[sgr_pkg::INTF_EMPTY];
            output_done_irq_enable  <= reg_wdata[sgr_pkg::INTF_DONE];
        end
    end

    assign irq = (buffer_empty_flag & buffer_empty_irq_enable)
               | (output_done_flag & output_done_irq_enable);

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // Reserved bits read zero.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                sgr_pkg::OFF_CLK:  reg_rdata <= {7'h00, debug_clock_run, 1'b0,
                                                clock_divider_select, 2'h0, clock_source_select};
                sgr_pkg::OFF_SEL:  reg_rdata <= {4'h0, tempo_duration_select, 5'h00,
                                                drive_mode_select, output_mode_select};
                sgr_pkg::OFF_CTL:  reg_rdata <= {7'h00, sound_stop, 7'h00, unit_enable};
                sgr_pkg::OFF_DAT:  reg_rdata <= sound_buffer_data;
                sgr_pkg::OFF_INTF: reg_rdata <= {7'h00, busy, 6'h00,
                                                buffer_empty_flag, output_done_flag};
                sgr_pkg::OFF_INTE: reg_rdata <= {14'h0000, buffer_empty_irq_enable,
                                                output_done_irq_enable};
                default:           reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule : sgr_top

//--- sim/sgr_top_monitor.sv
// Concurrent checks on the sound generator register port and buzzer pins.
// Assumes it is bound to sgr_top and sees only that module's ports.
module sgr_monitor (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [1:0]  reg_be,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        buzzer_out,
    input wire logic        buzzer_out_inverted,
    input wire logic        irq
);
    // Write shadows; checks that need a frozen generator gate on en_q.
    logic       en_q;
    logic [1:0] ie_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            en_q <= 1'b0;
            ie_q <= 2'h0;
        end else if (reg_wr && reg_addr == sgr_pkg::OFF_CTL) begin
            en_q <= reg_wdata[sgr_pkg::CTL_EN];
        end else if (reg_wr && reg_addr == sgr_pkg::OFF_INTE) begin
            ie_q <= reg_wdata[1:0];
        end
    end
    function automatic logic [15:0] live_bits(input logic [3:0] a);
        case (a)
            sgr_pkg::OFF_CLK:  return 16'h0173;
            sgr_pkg::OFF_SEL:  return 16'h0F07;
            sgr_pkg::OFF_CTL:  return 16'h0101;
            sgr_pkg::OFF_DAT:  return 16'hFFFF;
            sgr_pkg::OFF_INTF: return 16'h0103;
            sgr_pkg::OFF_INTE: return 16'h0003;
            default:           return 16'h0000;
        endcase
    endfunction
    sequence s_quiet_fill;
        reg_wr && reg_addr == sgr_pkg::OFF_DAT && reg_be == 2'h3 && !en_q;
    endsequence
    sequence s_quiet_done_clear;
        reg_wr && reg_addr == sgr_pkg::OFF_INTF && reg_wdata[0] && !en_q;
    endsequence
    sequence s_flag_read;
        reg_rd && reg_addr == sgr_pkg::OFF_INTF;
    endsequence
    property p_reserved_zero;
        reg_rd |=> (reg_rdata & ~live_bits($past(reg_addr))) == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits set");
    property p_rdata_quiet;
        !reg_rd |=> reg_rdata == 16'h0000;
    endproperty
    a_rdata_quiet: assert property (p_rdata_quiet)
        else $error("stray read data");
    property p_pin_pair;
        !buzzer_out_inverted |-> buzzer_out;
    endproperty
    a_pin_pair: assert property (p_pin_pair)
        else $error("pin pair both low");
    property p_fill_clears_empty;
        s_quiet_fill ##[1:2] s_flag_read |=> !reg_rdata[sgr_pkg::INTF_EMPTY];
    endproperty
    a_fill_clears_empty: assert property (p_fill_clears_empty)
        else $error("empty flag kept");
    property p_done_clear;
        s_quiet_done_clear ##[1:2] s_flag_read |=> !reg_rdata[sgr_pkg::INTF_DONE];
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("done flag kept");
    property p_disabled_still;
        !en_q [*4] |-> $stable(buzzer_out) && $stable(buzzer_out_inverted);
    endproperty
    a_disabled_still: assert property (p_disabled_still)
        else $error("pins moved while disabled");
    property p_irq_match;
        s_flag_read and !en_q |=> irq == |(reg_rdata[1:0] & ie_q);
    endproperty
    a_irq_match: assert property (p_irq_match)
        else $error("request mismatch");
    property p_irq_enable;
        irq |-> ie_q != 2'h0;
    endproperty
    a_irq_enable: assert property (p_irq_enable)
        else $error("request with no enable set");
endmodule // sgr_monitor

bind sgr_top sgr_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .buzzer_out(buzzer_out),
    .buzzer_out_inverted(buzzer_out_inverted), .irq(irq));

//--- sim/sgr_buzzer_model.sv
// Behavioural piezo load on the complementary buzzer pins.
// Assumes the pins are sampled on the system clock.
module sgr_buzzer_model (
    input  wire logic clk_sys,
    input  wire logic buzzer_out,
    input  wire logic buzzer_out_inverted,
    output int        pulses
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_q = 1'b0;
    initial pulses = 0;
    // Counts strokes; a rest or idle pin adds none.
    always @(posedge clk_sys) begin
        if (buzzer_out === 1'b1 && last_q === 1'b0) begin
            pulses <= pulses + 1;
        end
        last_q <= buzzer_out;
    end
endmodule // sgr_buzzer_model

//--- sim/testbench.sv
// Self-checking bench for the sound generator register bank.
// Assumes the plain strobe port and oscillator pins made from a counter.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys;
    logic        rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [1:0]  reg_be = 2'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [3:0]  src_clk = 4'h0;
    logic [7:0]  src_cnt = 8'h00;
    logic        debug_mode = 1'b0;
    logic        buzzer_out;
    logic        buzzer_out_inverted;
    logic        irq;
    logic [15:0] rd_val;
    int          pulses;
    int          p;
    int          num_errors = 0;
    int          tests_run = 0;
    logic [15:0] rst_vals [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h00FF, 16'h0002,
                                  16'h0000, 16'h0000};
    logic [3:0]  wr_addr [4] = '{4'h0, 4'h1, 4'h5, 4'h6};
    logic [15:0] wr_exp [4] = '{16'h0173, 16'h0F07, 16'h0003, 16'h0000};

    sgr_top dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .src_clk(src_clk), .debug_mode(debug_mode), .buzzer_out(buzzer_out),
        .buzzer_out_inverted(buzzer_out_inverted), .irq(irq));
    sgr_buzzer_model u_load (.clk_sys(clk_sys), .buzzer_out(buzzer_out),
        .buzzer_out_inverted(buzzer_out_inverted), .pulses(pulses));

    // ------------------------------------------------------------------
    // Clocks and bus tasks
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Oscillator pins are slow square waves so the synchronisers see every edge.
    always @(posedge clk_sys) begin
        src_cnt <= src_cnt + 8'h01;
        src_clk <= src_cnt[4:1];
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] be = 2'h3);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        reg_be    <= be;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
        tests_run++;
        if ((got & m) !== (exp & m)) begin
            num_errors++;
            $display("ERROR %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp,
                          input logic [15:0] m = 16'hFFFF);
        rd(a);
        chk(rd_val, exp, m);
    endtask
    task automatic wait_flag(input logic [3:0] a, input int b, input logic v);
        rd(a);
        for (int n = 0; n < 20000 && rd_val[b] !== v; n++) rd(a);
        chk_pin(rd_val[b], v);
    endtask
    task automatic close_out();
        $display("Checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        #900000;
        num_errors++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd_chk(4'(i), rst_vals[i]);
        end
        for (int i = 0; i < 4; i++) begin
            wr(wr_addr[i], 16'hFFFF);
            rd_chk(wr_addr[i], wr_exp[i]);
        end
        chk_pin(irq, 1'b1);
        wr(sgr_pkg::OFF_INTE, 16'h0001);
        chk_pin(irq, 1'b0);
        wr(sgr_pkg::OFF_CLK, 16'h0071);
        wr(sgr_pkg::OFF_CTL, 16'h0001);
        wr(sgr_pkg::OFF_CLK, 16'h0000);
        rd_chk(sgr_pkg::OFF_CLK, 16'h0071);
        wr(sgr_pkg::OFF_CTL, 16'h0000);
        wr(sgr_pkg::OFF_SEL, 16'h0005);
        wr(sgr_pkg::OFF_DAT, 16'h1234, 2'h1);
        rd_chk(sgr_pkg::OFF_DAT, 16'h00FF);
        rd_chk(sgr_pkg::OFF_INTF, 16'h0002, 16'h0002);
        wr(sgr_pkg::OFF_DAT, 16'h2004);
        rd_chk(sgr_pkg::OFF_DAT, 16'h2004);
        rd_chk(sgr_pkg::OFF_INTF, 16'h0000, 16'h0002);
        p = pulses;
        wr(sgr_pkg::OFF_CTL, 16'h0001);
        wait_flag(sgr_pkg::OFF_INTF, 0, 1'b1);
        rd_chk(sgr_pkg::OFF_INTF, 16'h0003, 16'h0103);
        chk_pin(irq, 1'b1);
        chk_pin(pulses > p, 1'b1);
        wr(sgr_pkg::OFF_INTF, 16'h0000);
        rd_chk(sgr_pkg::OFF_INTF, 16'h0001, 16'h0001);
        wr(sgr_pkg::OFF_INTF, 16'h0001);
        rd_chk(sgr_pkg::OFF_INTF, 16'h0000, 16'h0001);
        chk_pin(irq, 1'b0);
        wr(sgr_pkg::OFF_SEL, 16'h0004);
        wr(sgr_pkg::OFF_DAT, 16'h2004);
        wait_flag(sgr_pkg::OFF_INTF, 8, 1'b1);
        p = pulses;
        repeat (400) @(posedge clk_sys);
        chk_pin(pulses > p, 1'b1);
        debug_mode <= 1'b1;
        repeat (8) @(posedge clk_sys);
        p = pulses;
        repeat (200) @(posedge clk_sys);
        chk_pin(pulses == p, 1'b1);
        debug_mode <= 1'b0;
        wr(sgr_pkg::OFF_CTL, 16'h0101);
        wait_flag(sgr_pkg::OFF_CTL, 8, 1'b0);
        rd_chk(sgr_pkg::OFF_INTF, 16'h0002, 16'h0102);
        chk_pin(buzzer_out, 1'b0);
        wr(sgr_pkg::OFF_SEL, 16'h0006);
        p = pulses;
        wr(sgr_pkg::OFF_DAT, 16'h4104);
        wait_flag(sgr_pkg::OFF_INTF, 1, 1'b1);
        chk_pin(buzzer_out_inverted, 1'b1);
        wait_flag(sgr_pkg::OFF_INTF, 8, 1'b0);
        chk_pin(pulses == p, 1'b1);
        wr(sgr_pkg::OFF_CTL, 16'h0000);
        repeat (10) @(posedge clk_sys);
        close_out();
    end
endmodule // testbench
